/* shared/mgmt_payload_codec_params.svh */
// Purpose: offsets, field positions, reset values for the payload codec
// Assumes: 8-bit apb byte address, one aligned 32-bit word per register
// Notes: definitions only
`ifndef MGMT_PAYLOAD_CODEC_PARAMS_SVH
`define MGMT_PAYLOAD_CODEC_PARAMS_SVH
// register byte addresses
`define MPC_REG_NODE 8'h00
`define MPC_REG_CLUSTER_IDENTIFIER_LO 8'h04
`define MPC_REG_CLUSTER_IDENTIFIER_HI 8'h08
`define MPC_REG_REGISTRATION_IDENTIFIER_LO 8'h0c
`define MPC_REG_REGISTRATION_IDENTIFIER_HI 8'h10
`define MPC_REG_NEIGHBOUR_DOMAIN_IDENT 8'h14
`define MPC_REG_VERDICT 8'h18
`define MPC_REG_IND_START 8'h1c
`define MPC_REG_TBL_LEN 8'h20
`define MPC_REG_TBL_OCTET 8'h24
`define MPC_REG_RX_NEIGHBOUR_DOMAIN_IDENT 8'h28
`define MPC_REG_RX_SHIFT 8'h2c
`define MPC_REG_STATUS 8'h30
// payload octet positions
`define MPC_OCT_TAIL 5'h11
`define MPC_OCT_NUM_DOM 10'h012
`define MPC_OCT_LIST 10'h013
// verdict codes
`define MPC_VERDICT_ALIGN 8'h00
`define MPC_VERDICT_REFUSE 8'h01
// reset values
`define MPC_RST_VERDICT 8'h00
`define MPC_RST_ID 48'h0000_0000_0000
`endif

/* shared/mgmt_payload_codec_pkg.sv */
// Purpose: state types of the payload codec
// Assumes: nothing
// Notes: constants live in the params header
`default_nettype none
package mgmt_payload_codec_pkg;
  // outgoing framer states
  typedef enum logic [2:0] {F_IDLE, F_HDR, F_LEN_HI, F_LEN_LO, F_TBL} framer_e;
  // incoming parser states
  typedef enum logic [2:0] {P_HDR, P_LIST, P_SHIFT, P_DONE, P_SKIP} parser_e;
endpackage : mgmt_payload_codec_pkg
`default_nettype wire

/* tb/interdomain_mgmt_payload_codec_test.sv */
// Purpose: self-checking bench for the payload codec
// Assumes: apb slave answers within a bounded wait
// Notes: register rows first, then request, confirm and indication cases
`include "mgmt_payload_codec_params.svh"
`default_nettype none
module interdomain_mgmt_payload_codec_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] a; logic [31:0] d;} row_s;
  localparam logic [31:0] SHIFT_W = 32'h8000_0007; // forward, magnitude with its top bit set
  localparam logic [135:0] HV = {8'h3c, 8'h5a, 48'h1234_89ab_cdef, 48'h4b5a_0f1e_2d3c,
    24'hc0_ffee}; // expected header octets 0..16
  localparam logic [183:0] IV = {HV, 8'h02, 16'h0001, 8'ha5, 16'h0000};
  row_s rows[7] = '{'{8'h00, 32'h5a3c}, '{8'h04, 32'h89ab_cdef}, '{8'h08, 32'h1234},
    '{8'h0c, 32'h0f1e_2d3c}, '{8'h10, 32'h4b5a}, '{8'h14, 32'hc0_ffee}, '{8'h18, 32'h1}};
  logic clk_sys, reset_n, psel, penable, pwrite, pready, pslverr, stall, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic rx_valid, rx_last, rx_is_confirm, rx_ready, tx_valid, tx_last, tx_ready;
  logic [7:0] rx_data, tx_data;
  logic align_request_pulse, cycle_shift_direction;
  logic [30:0] cycle_start_shift;
  int errors = 0;
  int n_compared = 0;
  int n0;
  mgmt_payload_codec i_mgmt_payload_codec (.clk_sys(clk_sys), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_last(rx_last), .rx_is_confirm(rx_is_confirm), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
    .align_request_pulse(align_request_pulse), .cycle_shift_direction(cycle_shift_direction),
    .cycle_start_shift(cycle_start_shift));
  mgmt_peer_model i_mgmt_peer_model (.clk_sys(clk_sys), .reset_n(reset_n), .stall(stall),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last), .rx_is_confirm(rx_is_confirm),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
    .tx_ready(tx_ready));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // watchdog: the whole run is a few hundred cycles
  initial begin
    #(50 * 20000);
    errors++;
    test_done();
  end
  task automatic test_done();
    $display("errors=%0d n_compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_compared++;
    if (g !== x) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask : chk
  // one apb transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      t++;
    end while (pready !== 1'b1 && t < 100);
    // a slave that never answers counts as a mismatch
    if (pready !== 1'b1) chk(pready, 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  // reads one register until it shows the awaited value, then compares it
  task automatic poll(input logic [7:0] a, input logic [31:0] x);
    int k;
    k = 0;
    do begin
      apb(1'b0, a, 32'h0);
      k++;
    end while (r !== x && k < 200);
    chk(r, x);
  endtask : poll
  task automatic put(input logic c, input logic l, input logic [7:0] d);
    i_mgmt_peer_model.src.push_back({c, l, d});
  endtask : put
  // request: count at octet 18, entries then shift word, or cut after the entries
  task automatic send_req(input int n, input logic cut);
    logic [23:0] ent;
    for (int i = 0; i < 19; i++) put(1'b0, 1'b0, (i == 18) ? n[7:0] : i[7:0]);
    for (int i = 0; i < n; i++) begin
      ent = 24'h111111 * (i + 1);
      for (int b = 2; b >= 0; b--) put(1'b0, cut && i == n - 1 && b == 0, ent[8*b +: 8]);
    end
    if (!cut) for (int b = 3; b >= 0; b--) put(1'b0, b == 0, SHIFT_W[8*b +: 8]);
  endtask : send_req
  task automatic wait_msgs(input int k);
    int t;
    t = 0;
    while (i_mgmt_peer_model.n_last < k && t < 3000) begin
      @(posedge clk_sys);
      t++;
    end
    if (t == 3000) chk(1, 0);
  endtask : wait_msgs
  task automatic drain();
    while (i_mgmt_peer_model.src.size() > 0) @(posedge clk_sys);
    repeat (4) @(posedge clk_sys);
  endtask : drain
  initial begin
    {reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
    stall = 1'b1;
    repeat (20) @(posedge clk_sys);
    chk({rx_ready, tx_valid, pready, align_request_pulse}, 0); // reset levels
    reset_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0);
      chk(r, rows[i].d);
    end
    // both verdict codes, list of one and of two entries
    for (int v = 0; v < 2; v++) begin
      apb(1'b1, `MPC_REG_VERDICT, v);
      i_mgmt_peer_model.got.delete();
      send_req(v + 1, 1'b0);
      wait_msgs(v + 1);
      chk(i_mgmt_peer_model.got.size(), 18);
      for (int i = 0; i < 17; i++) chk(i_mgmt_peer_model.got[i], HV[135-8*i -: 8]);
      chk(i_mgmt_peer_model.got[17], v);
      chk(cycle_shift_direction, SHIFT_W[0]);
      chk(cycle_start_shift, SHIFT_W[31:1]);
      apb(1'b0, `MPC_REG_RX_NEIGHBOUR_DOMAIN_IDENT, 32'h0);
      chk(r, 24'h111111 * (v + 1));
      apb(1'b0, `MPC_REG_RX_SHIFT, 32'h0);
      chk(r, SHIFT_W);
    end
    // incoming confirmations: align, refuse, reserved
    for (int v = 0; v < 3; v++) begin
      for (int i = 0; i < 18; i++) put(1'b1, i == 17, (i == 17) ? v[7:0] : 8'h00);
      drain();
      apb(1'b0, `MPC_REG_STATUS, 32'h0);
      chk(r[3:1], 3'b001 << v);
    end
    // request cut short: no confirmation
    n0 = i_mgmt_peer_model.n_last;
    send_req(2, 1'b1);
    drain();
    repeat (40) @(posedge clk_sys);
    chk(i_mgmt_peer_model.n_last, n0);
    apb(1'b0, `MPC_REG_STATUS, 32'h0);
    chk(r[5], 1'b1);
    // indication with a one-octet table and an empty one, plus refusals
    i_mgmt_peer_model.got.delete();
    apb(1'b1, `MPC_REG_IND_START, 32'h2);
    chk(e, 1'b0);
    // table length is refused until the header has gone out
    poll(`MPC_REG_TBL_OCTET, 32'h2);
    apb(1'b1, `MPC_REG_TBL_LEN, 32'h1);
    chk(e, 1'b0);
    // octets are owed only once both length octets are queued
    poll(`MPC_REG_TBL_LEN, 32'h1);
    apb(1'b1, `MPC_REG_TBL_OCTET, 32'ha5);
    chk(e, 1'b0);
    apb(1'b1, `MPC_REG_TBL_LEN, 32'h0);
    chk(e, 1'b0);
    apb(1'b1, `MPC_REG_TBL_OCTET, 32'h5a);
    chk(e, 1'b1);
    apb(1'b0, 8'h3c, 32'h0);
    chk(e, 1'b1);
    wait_msgs(n0 + 1);
    chk(i_mgmt_peer_model.got.size(), 23);
    for (int i = 0; i < 23; i++) chk(i_mgmt_peer_model.got[i], IV[183-8*i -: 8]);
    test_done();
  end
endmodule : interdomain_mgmt_payload_codec_test
`default_nettype wire

/* tb/mgmt_payload_codec_checker.sv */
// Purpose: port-level checks of the payload codec
// Assumes: one clock domain, reset_n active low
// Notes: bound to every instance of the codec
`default_nettype none
module mgmt_payload_codec_checker (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  input wire logic rx_is_confirm,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic tx_ready,
  input wire logic align_request_pulse,
  input wire logic cycle_shift_direction,
  input wire logic [30:0] cycle_start_shift
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // a confirmation header must follow a complete request promptly
  sequence s_conf_start;
    ##[1:60] tx_valid;
  endsequence
  // a stalled octet must not change under the sink
  sequence s_tx_held;
    tx_valid && $stable(tx_data) && $stable(tx_last);
  endsequence
  property p_req_conf;
    align_request_pulse |-> s_conf_start;
  endproperty
  a_req_conf: assert property (p_req_conf) else $error("no confirmation after request");
  property p_pulse_one;
    align_request_pulse |=> !align_request_pulse;
  endproperty
  a_pulse_one: assert property (p_pulse_one) else $error("request pulse too long");
  property p_tx_hold;
    tx_valid && !tx_ready |=> s_tx_held;
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx octet dropped in stall");
  property p_shift_change;
    $changed({cycle_shift_direction, cycle_start_shift}) |->
      (align_request_pulse || $past(align_request_pulse));
  endproperty
  a_shift_change: assert property (p_shift_change) else $error("shift moved alone");
  property p_last_valid;
    tx_last |-> tx_valid;
  endproperty
  a_last_valid: assert property (p_last_valid) else $error("tx_last without valid");
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
  property p_rdata_idle;
    !pready |-> prdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("prdata not zero when idle");
  property p_unmapped;
    psel && penable && pready && paddr > 8'h30 |-> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
  c_conf: cover property (align_request_pulse);
endmodule : mgmt_payload_codec_checker
bind mgmt_payload_codec mgmt_payload_codec_checker i_mgmt_payload_codec_checker (
  .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last), .rx_is_confirm(rx_is_confirm),
  .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
  .tx_ready(tx_ready), .align_request_pulse(align_request_pulse),
  .cycle_shift_direction(cycle_shift_direction), .cycle_start_shift(cycle_start_shift));
`default_nettype wire

/* tb/mgmt_peer_model.sv */
// Purpose: peer management logic feeding and sinking payload octets
// Assumes: same clock as the codec
// Notes: stall toggles tx_ready so the two-entry buffer fills
`default_nettype none
module mgmt_peer_model (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic stall,
  output var logic rx_valid,
  output var logic [7:0] rx_data,
  output var logic rx_last,
  output var logic rx_is_confirm,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  output var logic tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] src[$]; // queued {confirm, last, octet}, msb-first fields
  logic [7:0] got[$]; // octets taken from the codec
  int n_last; // messages seen complete
  logic [9:0] nx; // next queued octet
  initial begin
    {rx_valid, rx_data, rx_last, rx_is_confirm, tx_ready} = '0;
    n_last = 0;
  end
  // source side: a released line shows the inverse so a stale octet never passes
  always @(posedge clk_sys) begin
    if (!rx_valid || rx_ready) begin
      if (src.size() > 0) begin
        nx = src.pop_front();
        rx_valid <= 1'b1;
        {rx_is_confirm, rx_last, rx_data} <= nx;
      end else begin
        rx_valid <= 1'b0;
        rx_data <= ~rx_data;
      end
    end
  end
  // sink side: octets taken only on valid and ready
  always @(posedge clk_sys) begin
    tx_ready <= stall ? ~tx_ready : 1'b1;
    if (reset_n && tx_valid && tx_ready) begin
      got.push_back(tx_data);
      if (tx_last) n_last++;
    end
  end
endmodule : mgmt_peer_model
`default_nettype wire

/* verilog/mgmt_payload_codec.sv */
// Purpose: builds confirmation and indication payloads, parses incoming ones
// Assumes: octet streams on the same clock, multi-octet fields msb first
// Notes: register access over apb, two-entry buffer ahead of tx
`include "mgmt_payload_codec_params.svh"
`default_nettype none
module mgmt_payload_codec
  import mgmt_payload_codec_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  input wire logic rx_is_confirm,
  output logic rx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last,
  input wire logic tx_ready,
  output logic align_request_pulse,
  output logic cycle_shift_direction,
  output logic [30:0] cycle_start_shift
);

  // configuration held for the common header
  logic [7:0] node_number_q;
  logic [7:0] domain_designator_q;
  logic [47:0] cluster_identifier_q;
  logic [47:0] registration_identifier_q;
  logic [23:0] neighbour_domain_ident_q;
  logic [7:0] verdict_q; // answer placed in every confirmation

  // framer state
  framer_e fst_q;
  logic [4:0] idx_q; // header octet index
  logic is_cnf_q; // header belongs to a confirmation
  logic [7:0] count_q; // tables announced
  logic [7:0] tbl_left_q; // tables not yet finished
  logic [15:0] len_q; // length of current table
  logic [15:0] oct_left_q; // octets still owed by software
  logic cnf_pend_q; // confirmation waiting for the framer

  // parser state
  parser_e pst_q;
  logic [9:0] rx_cnt_q; // octet index in current message
  logic rx_kind_q; // 1 when message is a confirmation
  logic [7:0] dom_left_q; // list entries still to come
  logic [1:0] sub_q; // octet within entry or shift word
  logic [23:0] ent_q; // list entry being assembled
  logic [31:0] shw_q; // shift word being assembled
  logic [23:0] rx_neighbour_domain_ident_q; // last list entry of last request
  logic [31:0] rx_shift_q; // shift word of last request
  logic [5:0] stat_q; // status flags

  // apb answer and tx buffer registers
  logic pready_q, pslverr_q;
  logic [31:0] prdata_q;
  logic out_v_q, out_l_q, skid_v_q, skid_l_q;
  logic [7:0] out_d_q, skid_d_q;
  logic rx_ready_q, pulse_q;

  // apb decode
  wire acc = psel & penable & ~pready_q;
  wire wr = acc & pwrite;
  wire is_start = paddr == `MPC_REG_IND_START;
  wire is_len = paddr == `MPC_REG_TBL_LEN;
  wire is_oct = paddr == `MPC_REG_TBL_OCTET;
  wire in_tbl = fst_q == F_TBL;
  wire len_ok = in_tbl & (oct_left_q == 16'h0000) & (tbl_left_q != 8'h00);
  wire oct_ok = in_tbl & (oct_left_q != 16'h0000);
  wire start_ok = (fst_q == F_IDLE) & ~cnf_pend_q;
  wire buf_in_ready = ~skid_v_q;
  // a table octet waits for buffer room instead of failing
  wire hold = wr & is_oct & oct_ok & ~buf_in_ready;
  wire done = acc & ~hold;
  logic mapped;
  logic [31:0] rd_word;

  // read mux; unused upper bits read zero
  always_comb begin
    mapped = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (paddr)
      `MPC_REG_NODE: rd_word = {16'h0000, domain_designator_q, node_number_q};
      `MPC_REG_CLUSTER_IDENTIFIER_LO: rd_word = cluster_identifier_q[31:0];
      `MPC_REG_CLUSTER_IDENTIFIER_HI: rd_word = {16'h0000, cluster_identifier_q[47:32]};
      `MPC_REG_REGISTRATION_IDENTIFIER_LO: rd_word = registration_identifier_q[31:0];
      `MPC_REG_REGISTRATION_IDENTIFIER_HI: rd_word = {16'h0000, registration_identifier_q[47:32]};
      `MPC_REG_NEIGHBOUR_DOMAIN_IDENT: rd_word = {8'h00, neighbour_domain_ident_q};
      `MPC_REG_VERDICT: rd_word = {24'h000000, verdict_q};
      `MPC_REG_IND_START: rd_word = {24'h000000, count_q};
      `MPC_REG_TBL_LEN: rd_word = {16'h0000, oct_left_q};
      `MPC_REG_TBL_OCTET: rd_word = {24'h000000, tbl_left_q};
      `MPC_REG_RX_NEIGHBOUR_DOMAIN_IDENT: rd_word = {8'h00, rx_neighbour_domain_ident_q};
      `MPC_REG_RX_SHIFT: rd_word = rx_shift_q;
      `MPC_REG_STATUS: rd_word = {26'h0000000, stat_q};
      default: mapped = 1'b0; // unmapped answers with an error
    endcase
  end

  // refusals: unmapped, or a framer command in the wrong phase
  wire bad = ~mapped | (pwrite & is_start & ~start_ok) | (pwrite & is_len & ~len_ok)
    | (pwrite & is_oct & ~oct_ok);
  wire wr_go = done & pwrite & ~bad;
  wire start_go = wr_go & is_start;
  wire len_go = wr_go & is_len;
  wire sw_push = wr_go & is_oct;

  // common header as one vector, octet 0 in the top byte
  wire [7:0] tail = is_cnf_q ? verdict_q : count_q;
  wire [143:0] hdr_vec = {node_number_q, domain_designator_q, cluster_identifier_q,
    registration_identifier_q, neighbour_domain_ident_q, tail};
  wire [4:0] sel = `MPC_OCT_TAIL - idx_q;
  wire [7:0] hdr_oct = hdr_vec[{sel, 3'b000} +: 8];

  // framer octet source
  wire fr_valid = (fst_q == F_HDR) | (fst_q == F_LEN_HI) | (fst_q == F_LEN_LO);
  wire at_tail = idx_q == `MPC_OCT_TAIL;
  wire last_tbl = tbl_left_q == 8'h01;
  wire [7:0] fr_data = (fst_q == F_HDR) ? hdr_oct :
    (fst_q == F_LEN_HI) ? len_q[15:8] : len_q[7:0];
  wire fr_last = ((fst_q == F_HDR) & at_tail & (is_cnf_q | (count_q == 8'h00)))
    | ((fst_q == F_LEN_LO) & (len_q == 16'h0000) & last_tbl);
  wire fr_push = fr_valid & buf_in_ready;
  wire in_valid = fr_push | sw_push; // never both: no emission in F_TBL
  wire [7:0] in_data = sw_push ? pwdata[7:0] : fr_data;
  wire in_last = sw_push ? ((oct_left_q == 16'h0001) & last_tbl) : fr_last;

  // parser side
  wire rx_take = rx_valid & rx_ready_q;
  // a request is whole once its fourth shift octet arrives; extra octets are allowed
  wire shift_end = (pst_q == P_SHIFT) & (sub_q == 2'b11);
  wire parse_ok = (pst_q == P_DONE) | shift_end;
  wire req_end = rx_take & rx_last & ~rx_kind_q & parse_ok;
  wire cnf_start = (fst_q == F_IDLE) & cnf_pend_q;
  wire cnf_pend_d = req_end | (cnf_pend_q & ~cnf_start); // set wins over take

  // apb answer registered; access phase takes at least two cycles
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= done;
      pslverr_q <= done & bad;
      prdata_q <= (done & ~pwrite & mapped) ? rd_word : 32'h0000_0000;
    end
  end

  // configuration writes
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      node_number_q <= 8'h00;
      domain_designator_q <= 8'h00;
      cluster_identifier_q <= `MPC_RST_ID;
      registration_identifier_q <= `MPC_RST_ID;
      neighbour_domain_ident_q <= 24'h000000;
      verdict_q <= `MPC_RST_VERDICT;
    end else if (wr_go) begin
      unique case (paddr)
        `MPC_REG_NODE: {domain_designator_q, node_number_q} <= pwdata[15:0];
        `MPC_REG_CLUSTER_IDENTIFIER_LO: cluster_identifier_q[31:0] <= pwdata;
        `MPC_REG_CLUSTER_IDENTIFIER_HI: cluster_identifier_q[47:32] <= pwdata[15:0];
        `MPC_REG_REGISTRATION_IDENTIFIER_LO: registration_identifier_q[31:0] <= pwdata;
        `MPC_REG_REGISTRATION_IDENTIFIER_HI: registration_identifier_q[47:32] <= pwdata[15:0];
        `MPC_REG_NEIGHBOUR_DOMAIN_IDENT: neighbour_domain_ident_q <= pwdata[23:0];
        `MPC_REG_VERDICT: verdict_q <= pwdata[7:0];
        default: ; // read-only or command words
      endcase
    end
  end

  // framer: confirmation has priority over a new indication
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fst_q <= F_IDLE;
      idx_q <= 5'h00;
      is_cnf_q <= 1'b0;
      count_q <= 8'h00;
      tbl_left_q <= 8'h00;
      len_q <= 16'h0000;
      oct_left_q <= 16'h0000;
      cnf_pend_q <= 1'b0;
    end else begin
      cnf_pend_q <= cnf_pend_d;
      unique case (fst_q)
        F_IDLE: begin
          idx_q <= 5'h00;
          if (cnf_start) begin
            is_cnf_q <= 1'b1;
            fst_q <= F_HDR;
          end else if (start_go) begin
            is_cnf_q <= 1'b0;
            count_q <= pwdata[7:0];
            fst_q <= F_HDR;
          end
        end
        F_HDR: if (fr_push) begin
          idx_q <= idx_q + 5'h01;
          if (at_tail) begin
            tbl_left_q <= is_cnf_q ? 8'h00 : count_q;
            fst_q <= fr_last ? F_IDLE : F_TBL;
          end
        end
        F_TBL: if (len_go) begin
          len_q <= pwdata[15:0];
          fst_q <= F_LEN_HI;
        end else if (sw_push) begin
          oct_left_q <= oct_left_q - 16'h0001;
          if (oct_left_q == 16'h0001) begin
            tbl_left_q <= tbl_left_q - 8'h01;
            if (last_tbl) fst_q <= F_IDLE;
          end
        end
        F_LEN_HI: if (fr_push) fst_q <= F_LEN_LO;
        F_LEN_LO: if (fr_push) begin
          oct_left_q <= len_q;
          if (len_q == 16'h0000) begin
            // an empty table ends at its length field
            tbl_left_q <= tbl_left_q - 8'h01;
            fst_q <= last_tbl ? F_IDLE : F_TBL;
          end else begin
            fst_q <= F_TBL;
          end
        end
        default: fst_q <= F_IDLE; // three-bit code has spare values
      endcase
    end
  end

  // two-entry buffer: output stage plus skid stage, no word lost on stall
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      out_v_q <= 1'b0;
      out_d_q <= 8'h00;
      out_l_q <= 1'b0;
      skid_v_q <= 1'b0;
      skid_d_q <= 8'h00;
      skid_l_q <= 1'b0;
    end else begin
      if (~out_v_q | tx_ready) begin
        // output stage frees up: refill from skid, else from input
        out_v_q <= skid_v_q | in_valid;
        out_d_q <= skid_v_q ? skid_d_q : in_data;
        out_l_q <= skid_v_q ? skid_l_q : in_last;
        skid_v_q <= skid_v_q & in_valid;
        if (skid_v_q & in_valid) begin
          skid_d_q <= in_data;
          skid_l_q <= in_last;
        end
      end else if (in_valid) begin
        skid_v_q <= 1'b1;
        skid_d_q <= in_data;
        skid_l_q <= in_last;
      end
    end
  end

  // parser: octet counting and field capture
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pst_q <= P_HDR;
      rx_cnt_q <= 10'h000;
      rx_kind_q <= 1'b0;
      dom_left_q <= 8'h00;
      sub_q <= 2'b00;
      ent_q <= 24'h000000;
      shw_q <= 32'h0000_0000;
    end else if (rx_take) begin
      rx_cnt_q <= rx_last ? 10'h000 : rx_cnt_q + 10'h001;
      if (rx_cnt_q == 10'h000) rx_kind_q <= rx_is_confirm;
      unique case (pst_q)
        P_HDR: if (~rx_kind_q & (rx_cnt_q == `MPC_OCT_NUM_DOM)) begin
          dom_left_q <= rx_data;
          sub_q <= 2'b00;
          pst_q <= (rx_data == 8'h00) ? P_SHIFT : P_LIST;
        end else if (rx_kind_q & (rx_cnt_q == {5'h00, `MPC_OCT_TAIL})) begin
          pst_q <= P_SKIP; // verdict taken in status process
        end
        P_LIST: begin
          ent_q <= {ent_q[15:0], rx_data};
          sub_q <= (sub_q == 2'b10) ? 2'b00 : sub_q + 2'b01;
          if (sub_q == 2'b10) begin
            dom_left_q <= dom_left_q - 8'h01;
            if (dom_left_q == 8'h01) pst_q <= P_SHIFT;
          end
        end
        P_SHIFT: begin
          shw_q <= {shw_q[23:0], rx_data};
          sub_q <= sub_q + 2'b01;
          if (sub_q == 2'b11) pst_q <= P_DONE;
        end
        default: ; // extra octets are ignored
      endcase
      // the last octet of a message returns the parse to P_HDR
      if (rx_last) pst_q <= P_HDR;
      // a confirmation of a single octet also returns the parse to P_HDR
      if (rx_cnt_q == 10'h000 & rx_is_confirm & rx_last) pst_q <= P_HDR;
    end
  end

  // status: [0] request seen, [1] align, [2] refuse, [3] unrecognised,
  // [4] framer busy, [5] request cut short
  wire cnf_verdict = rx_take & rx_kind_q & (pst_q == P_HDR)
    & (rx_cnt_q == {5'h00, `MPC_OCT_TAIL});
  wire short_req = rx_take & rx_last & ~rx_kind_q & ~parse_ok;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      stat_q <= 6'h00;
      rx_neighbour_domain_ident_q <= 24'h000000;
      rx_shift_q <= 32'h0000_0000;
      pulse_q <= 1'b0;
      rx_ready_q <= 1'b0;
    end else begin
      pulse_q <= req_end;
      // a second request stalls until its answer can be queued
      rx_ready_q <= ~cnf_pend_d;
      stat_q[4] <= fst_q != F_IDLE;
      if (req_end) begin
        stat_q[0] <= 1'b1;
        stat_q[5] <= 1'b0;
        rx_neighbour_domain_ident_q <= ent_q; // last complete entry stays in ent_q
        // the final shift octet is still on rx_data at this edge
        rx_shift_q <= shift_end ? {shw_q[23:0], rx_data} : shw_q;
      end
      if (short_req) stat_q[5] <= 1'b1;
      if (cnf_verdict) begin
        // reserved codes are neither acceptance nor refusal
        stat_q[1] <= rx_data == `MPC_VERDICT_ALIGN;
        stat_q[2] <= rx_data == `MPC_VERDICT_REFUSE;
        stat_q[3] <= (rx_data != `MPC_VERDICT_ALIGN) & (rx_data != `MPC_VERDICT_REFUSE);
      end
    end
  end

  // ports straight from flops; request octet 17 reserved bits never read
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign rx_ready = rx_ready_q;
  assign tx_valid = out_v_q;
  assign tx_data = out_d_q;
  assign tx_last = out_l_q;
  assign align_request_pulse = pulse_q;
  assign cycle_shift_direction = rx_shift_q[0];
  assign cycle_start_shift = rx_shift_q[31:1];

endmodule : mgmt_payload_codec
`default_nettype wire
